// ---- gpiox_port.sv ----
// eight-pin port: APB registers, pin drivers, alternate functions, interrupts
// assumes an APB master on i_clk; pins and peripherals drive the i_ signals
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module gpiox_port #(
	parameter int          W        = gpiox_pkg::GPIOX_PINS,
	parameter int          NSRC     = gpiox_pkg::GPIOX_SRCS,
	parameter logic [15:0] SRC_PINS = gpiox_pkg::SRC_PINS_DEF,
	parameter logic [7:0]  IRQ_PINS = gpiox_pkg::IRQ_CAPABLE
) (
	input  wire logic                          i_clk,
	input  wire logic                          i_rst_n,
	// apb slave
	input  wire logic                          i_psel,
	input  wire logic                          i_penable,
	input  wire logic                          i_pwrite,
	input  wire logic [gpiox_pkg::GPIOX_AW-1:0] i_paddr,
	input  wire logic [gpiox_pkg::GPIOX_DW-1:0] i_pwdata,
	output logic      [gpiox_pkg::GPIOX_DW-1:0] o_prdata,
	output logic                               o_pready,
	output logic                               o_pslverr,
	// pad side
	input  wire logic [W-1:0]                  i_pin_in,
	output logic      [W-1:0]                  o_pin_out,
	output logic      [W-1:0]                  o_pin_oe,
	output logic      [W-1:0]                  o_pullup_en,
	// peripheral alternate functions
	input  wire logic [W-1:0]                  i_alt_en,
	input  wire logic [W-1:0]                  i_alt_out_en,
	input  wire logic [W-1:0]                  i_alt_out,
	input  wire logic [W-1:0]                  i_alt_od,
	output logic      [W-1:0]                  o_alt_in,
	// interrupt controller side
	input  wire logic [NSRC-1:0]               i_vec_fetch,
	output logic      [NSRC-1:0]               o_ext_irq_source,
	output logic                               o_wake
);
	import gpiox_pkg::*;

	localparam int SW = NSRC * SENS_W;

	logic [W-1:0]  port_data_r;
	logic [W-1:0]  port_direction_r;
	logic [W-1:0]  port_option_r;
	logic [SW-1:0] ext_irq_sensitivity_ctrl_r;
	logic [W-1:0]  pin_s1_r;
	logic [W-1:0]  pin_s2_r;
	logic [W-1:0]  alt_drv;
	logic [W-1:0]  eff_dir;
	logic [W-1:0]  eff_val;
	logic [W-1:0]  eff_pp;
	logic [W-1:0]  rd_data;
	logic [W-1:0]  irq_pin_en;
	logic [NSRC-1:0] req;
	logic          wr_en;
	logic          rd_setup;
	logic          addr_ok;
	logic [GPIOX_DW-1:0] rd_mux;
	logic [GPIOX_DW-1:0] prdata_r;
	logic [W-1:0]  pin_out_r;
	logic [W-1:0]  pin_oe_r;
	logic [W-1:0]  pullup_r;
	logic [W-1:0]  alt_in_r;

	// pad levels are asynchronous; s1 feeds only s2
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_s1_r <= RST_PORT;
			pin_s2_r <= RST_PORT;
		end else begin
			pin_s1_r <= i_pin_in; // R23
			pin_s2_r <= pin_s1_r; // R23
		end
	end

	// apb decode; zero wait states so pready is always high
	assign o_pready = 1'b1;
	assign wr_en    = i_psel & i_penable & i_pwrite;
	assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
	always_comb begin
		unique case (i_paddr)
			OFS_PORT_DATA, OFS_PORT_DIR, OFS_PORT_OPT,
			OFS_SENS_CTRL, OFS_IRQ_STATE: addr_ok = 1'b1;
			default:                      addr_ok = 1'b0;
		endcase
	end
	// unmapped address answers with an error, writes ignored
	assign o_pslverr = i_psel & i_penable & ~addr_ok;

	// data latch: written in every mode, drives pin only when output
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			port_data_r <= RST_PORT;
		end else if (wr_en && i_paddr == OFS_PORT_DATA) begin
			port_data_r <= i_pwdata[W-1:0]; // R3 R11
		end
	end

	// direction, one bit per pin
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			port_direction_r <= RST_PORT;
		end else if (wr_en && i_paddr == OFS_PORT_DIR) begin
			port_direction_r <= i_pwdata[W-1:0]; // R1
		end
	end

	// option: pull-up in input, push-pull in output
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			port_option_r <= RST_PORT;
		end else if (wr_en && i_paddr == OFS_PORT_OPT) begin
			port_option_r <= i_pwdata[W-1:0]; // R1
		end
	end

	// sensitivity fields, two bits per source
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_irq_sensitivity_ctrl_r <= RST_SENS[SW-1:0];
		end else if (wr_en && i_paddr == OFS_SENS_CTRL) begin
			ext_irq_sensitivity_ctrl_r <= i_pwdata[SW-1:0]; // R7
		end
	end

	// alternate function overrides the register programming
	always_comb begin
		alt_drv = i_alt_en & i_alt_out_en; // R14
		eff_dir = port_direction_r | alt_drv; // R15
		eff_val = (alt_drv & i_alt_out) | (~alt_drv & port_data_r); // R14
		eff_pp  = (alt_drv & ~i_alt_od) | (~alt_drv & port_option_r); // R15
	end

	// pad controls registered so they change cleanly once per clock
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_out_r <= RST_PORT;
			pin_oe_r  <= RST_PORT;
			pullup_r  <= RST_PORT;
		end else begin
			pin_out_r <= eff_val; // R11
			// low drives in both modes; high only when push-pull
			pin_oe_r  <= eff_dir & (~eff_val | eff_pp); // R12 R13
			// pull-up only for inputs; input pins never drive
			pullup_r  <= ~eff_dir & port_option_r; // R13 R2
		end
	end
	assign o_pin_out   = pin_out_r;
	assign o_pin_oe    = pin_oe_r;
	assign o_pullup_en = pullup_r;

	// peripheral input: output pins hand over the latch instead of the pad
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			alt_in_r <= RST_PORT;
		end else begin
			alt_in_r <= (port_direction_r & port_data_r)
			            | (~port_direction_r & pin_s2_r); // R19 R16
		end
	end
	assign o_alt_in = alt_in_r;

	// data read view per pin
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (port_direction_r[i]) begin
				rd_data[i] = port_data_r[i]; // R11
			end else if (alt_drv[i]) begin
				rd_data[i] = i_alt_out[i]; // R18
			end else begin
				rd_data[i] = pin_s2_r[i]; // R2
			end
		end
	end

	// read mux; narrow registers sit in the low bits
	always_comb begin
		rd_mux = {GPIOX_DW{1'b0}};
		unique case (i_paddr)
			OFS_PORT_DATA: rd_mux[W-1:0]    = rd_data;
			OFS_PORT_DIR:  rd_mux[W-1:0]    = port_direction_r;
			OFS_PORT_OPT:  rd_mux[W-1:0]    = port_option_r;
			OFS_SENS_CTRL: rd_mux[SW-1:0]   = ext_irq_sensitivity_ctrl_r;
			OFS_IRQ_STATE: rd_mux[NSRC-1:0] = req;
			default:       rd_mux           = {GPIOX_DW{1'b0}};
		endcase
	end

	// read data captured in the setup cycle, held through the access
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_r <= rd_mux;
		end
	end
	assign o_prdata = prdata_r;

	// input-with-interrupt: direction clear, option set, pin capable
	assign irq_pin_en = ~port_direction_r & port_option_r & IRQ_PINS[W-1:0]; // R6

	// one detector per vector, each sees only its own pin group
	for (genvar s = 0; s < NSRC; s++) begin : g_src
		gpiox_irq_if #(.W(W)) irq ();
		gpiox_irq_det #(.W(W)) u_det (
			.i_clk   (i_clk),
			.i_rst_n (i_rst_n),
			.irq     (irq.det)
		);
		assign irq.lvl   = pin_s2_r; // R23
		assign irq.en    = irq_pin_en & SRC_PINS[s*W +: W]; // R8
		assign irq.sens  = gpiox_sens_e'(ext_irq_sensitivity_ctrl_r[s*SENS_W +: SENS_W]); // R7
		// only a real change of this source's field discards the request
		assign irq.sens_chg = wr_en && (i_paddr == OFS_SENS_CTRL)
		                      && (i_pwdata[s*SENS_W +: SENS_W]
		                          != ext_irq_sensitivity_ctrl_r[s*SENS_W +: SENS_W]); // R10
		assign irq.fetch = i_vec_fetch[s]; // R9
		assign req[s]    = irq.req;
	end

	// requests go to the cpu; clocks may be stopped, so wake is the same level
	assign o_ext_irq_source = req; // R6
	assign o_wake           = |req; // R22

endmodule : gpiox_port

// ---- gpiox_pkg.sv ----
// constants for the eight-pin port with external interrupt detection
// assumes one 10 MHz clock, APB register access, 32-bit aligned words
// Contract
// R1 - eight pins, bit n of every port register controls pin n
// R2 - direction clear: pin is input, data read returns pin level
// R3 - input pin: data write changes only the latch, not the pin
// R4 - software writes data before switching a pin from input to output
// R5 - software avoids bit set/clear read-modify-write on the data register
// R6 - input-with-interrupt pin raises external request on an event, pins independent
// R7 - edge or level sensitivity selected per source in sensitivity control register
// R8 - pins sharing a vector detected per sensitivity, then ORed
// R9 - request latch hidden from software, cleared on vector fetch (here software can read it at OFS_IRQ_STATE)
// R10 - writing a changed sensitivity field discards the pending request
// R11 - direction set: pin is output, reads return stored latch
// R12 - option selects push-pull or open-drain; 1 floats in open-drain
// R13 - input option selects pull-up; high driver only for push-pull output
// R14 - peripheral using a pin overrides normal port programming automatically
// R15 - peripheral output forces output mode, push-pull or open-drain as asked
// R16 - software sets pin as input for peripheral input; level stays readable
// R17 - pin used both ways by peripheral configured as floating input
// R18 - input pin with alternate output: data read returns alternate output
// R19 - output pin with alternate input: peripheral receives data latch
// R20 - software never enables alternate function on input-with-interrupt pin
// R21 - analog converter pin configured as floating input by software
// R22 - low-power states leave port alone; external requests wake device
// R23 - pin inputs pass two flip-flops before reads and detection
package gpiox_pkg;

	localparam int          GPIOX_PINS     = 8;
	localparam int          GPIOX_SRCS     = 2;
	localparam int          GPIOX_AW       = 12;
	localparam int          GPIOX_DW       = 32;

	// register byte offsets
	localparam logic [11:0] OFS_PORT_DATA  = 12'h000;
	localparam logic [11:0] OFS_PORT_DIR   = 12'h004;
	localparam logic [11:0] OFS_PORT_OPT   = 12'h008;
	localparam logic [11:0] OFS_SENS_CTRL  = 12'h00C;
	localparam logic [11:0] OFS_IRQ_STATE  = 12'h010;

	// all port registers clear at reset
	localparam logic [7:0]  RST_PORT       = 8'h00;
	localparam logic [3:0]  RST_SENS       = 4'h0;

	// sensitivity field: two bits per source, source s at bit 2*s
	localparam int          SENS_W         = 2;
	localparam int          SENS_POS0      = 0;

	// pins belonging to each source, source 0 in the low byte
	localparam logic [15:0] SRC_PINS_DEF   = 16'hF00F;
	localparam logic [7:0]  IRQ_CAPABLE    = 8'hFF;

	typedef enum logic [1:0] {
		SENS_FALL_LOW,
		SENS_RISE,
		SENS_FALL,
		SENS_BOTH
	} gpiox_sens_e;

endpackage : gpiox_pkg

// ---- gpiox_irq_if.sv ----
// carrier between the port core and one interrupt source detector
// assumes both ends share the port clock
`timescale 1ns/1ps
interface gpiox_irq_if #(
	parameter int W = 8
);
	import gpiox_pkg::*;

	logic [W-1:0] lvl;
	logic [W-1:0] en;
	gpiox_sens_e  sens;
	logic         sens_chg;
	logic         fetch;
	logic         req;

	modport ctl (output lvl, output en, output sens, output sens_chg, output fetch, input req);
	modport det (input lvl, input en, input sens, input sens_chg, input fetch, output req);
endinterface : gpiox_irq_if

// ---- gpiox_irq_det.sv ----
// one external interrupt source: per-pin detection, OR, request latch
// assumes levels arrive already synchronised to i_clk
`timescale 1ns/1ps
module gpiox_irq_det #(
	parameter int W = 8
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	gpiox_irq_if.det  irq
);
	import gpiox_pkg::*;

	logic [W-1:0] prev_r;
	logic         hit;
	logic         req_r;

	// event test for one pin under the programmed sensitivity
	function automatic logic pin_event(input gpiox_sens_e s, input logic cur, input logic old);
		unique case (s)
			SENS_FALL_LOW: pin_event = ~cur;
			SENS_RISE:     pin_event = cur & ~old;
			SENS_FALL:     pin_event = ~cur & old;
			SENS_BOTH:     pin_event = cur ^ old;
		endcase
	endfunction : pin_event

	// previous level for edge detection
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_r <= {W{1'b0}};
		end else begin
			prev_r <= irq.lvl;
		end
	end

	// detect each pin first, then combine
	always_comb begin
		hit = 1'b0;
		for (int i = 0; i < W; i++) begin
			hit = hit | (irq.en[i] & pin_event(irq.sens, irq.lvl[i], prev_r[i])); // R8 R6
		end
	end

	// request latch, readable at OFS_IRQ_STATE; a new event wins over fetch or sensitivity rewrite
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_r <= 1'b0;
		end else if (hit) begin
			req_r <= 1'b1; // R6
		end else if (irq.fetch || irq.sens_chg) begin
			req_r <= 1'b0; // R9 R10
		end
	end

	assign irq.req = req_r;

endmodule : gpiox_irq_det

// ---- gpiox_pad_model.sv ----
// pad model: resolves each pin from port drive, outside driver, pull-up
// assumes the bench supplies the outside driver value and its enable
`timescale 1ns/1ps
module gpiox_pad_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_out,
	input  wire logic [7:0] i_oe,
	input  wire logic [7:0] i_pu,
	input  wire logic [7:0] i_ext,
	input  wire logic [7:0] i_ext_en,
	output logic      [7:0] o_pad
);
	logic [7:0] noise_r = 8'h55;
	// floating pins wander so a stale level never reads back as valid
	always_ff @(posedge i_clk) begin
		noise_r <= ~noise_r;
	end
	// port drive wins, then the outside driver, then pull-up or noise
	assign o_pad = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
		| (~i_oe & ~i_ext_en & (i_pu | noise_r));
endmodule : gpiox_pad_model

// ---- gpiox_port_chk.sv ----
// checker for the port: apb answer, pad drive, request latch
// assumes binding to gpiox_port with eight pins and two sources
`timescale 1ns/1ps
module gpiox_port_chk (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [7:0]  i_pin_in,
	input wire logic [7:0]  o_pin_out,
	input wire logic [7:0]  o_pin_oe,
	input wire logic [7:0]  o_pullup_en,
	input wire logic [7:0]  i_alt_en,
	input wire logic [7:0]  i_alt_out_en,
	input wire logic [7:0]  i_alt_out,
	input wire logic [7:0]  i_alt_od,
	input wire logic [1:0]  i_vec_fetch,
	input wire logic [1:0]  o_ext_irq_source,
	input wire logic        o_wake
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic [7:0] drv;
	// pins that a peripheral drives as output
	assign drv = i_alt_en & i_alt_out_en;
	sequence src0_high;
		(i_pin_in[3:0] == 4'hF) [*4];
	endsequence
	chk_ready_always: assert property (o_pready) else $error("pready low");
	chk_unmapped_err: assert property (i_psel && i_penable && i_paddr > 12'h010
		|-> o_pslverr && o_prdata == 32'h0) else $error("unmapped access not refused");
	chk_pull_not_driven: assert property ((o_pullup_en & o_pin_oe) == 8'h0)
		else $error("pull-up on a driven pin");
	chk_alt_out_val: assert property (|drv |=>
		((o_pin_out ^ $past(i_alt_out)) & $past(drv)) == 8'h0) else $error("alt value");
	chk_alt_out_oe: assert property (|drv |=>
		((o_pin_oe ^ $past(~i_alt_od | ~i_alt_out)) & $past(drv)) == 8'h0)
		else $error("alt drive mode");
	chk_wake_or_req: assert property (o_wake == |o_ext_irq_source)
		else $error("wake not or of requests");
	chk_fetch_clears: assert property (src0_high ##0 i_vec_fetch[0]
		|=> !o_ext_irq_source[0]) else $error("fetch did not clear");
	chk_req_has_cause: assert property ($rose(o_ext_irq_source[1]) |->
		$past(i_pin_in[7:4], 3) != $past(i_pin_in[7:4], 4) || !(&$past(i_pin_in[7:4], 3)))
		else $error("request without pin event");
endmodule : gpiox_port_chk
bind gpiox_port gpiox_port_chk u_chk (.*);

// ---- testbench.sv ----
// self-checking bench for the port: registers, pads, alternates, requests
// assumes the pad model and the bound checker beside the design
`timescale 1ns/1ps
module testbench;
	import gpiox_pkg::*;
	logic        i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_wake, err;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic [7:0]  i_pin_in, o_pin_out, o_pin_oe, o_pullup_en, o_alt_in, ext, ext_en;
	logic [7:0]  i_alt_en, i_alt_out_en, i_alt_out, i_alt_od;
	logic [1:0]  i_vec_fetch, o_ext_irq_source;
	int          bad_count, total_checks;

	gpiox_port dut (.*);
	gpiox_pad_model pad (.i_clk(i_clk), .i_out(o_pin_out), .i_oe(o_pin_oe),
		.i_pu(o_pullup_en), .i_ext(ext), .i_ext_en(ext_en), .o_pad(i_pin_in));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask : cmp
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_psel   <= 1'b1;
		i_pwrite <= w;
		i_paddr  <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic put(input logic [7:0] v);
		@(posedge i_clk);
		ext <= v;
		repeat (4) @(negedge i_clk);
	endtask : put
	task automatic fetch(input logic [1:0] s);
		@(posedge i_clk);
		i_vec_fetch <= s;
		@(posedge i_clk);
		i_vec_fetch <= 2'b00;
	endtask : fetch
	task automatic wait_irq(input logic [1:0] exp);
		repeat (10) begin
			@(negedge i_clk);
			if (o_ext_irq_source === exp) break;
		end
		cmp(o_ext_irq_source, exp, "request");
	endtask : wait_irq
	task automatic t_reset;
		cmp({o_pin_out, o_pin_oe, o_pullup_en, o_alt_in}, 32'h0, "reset pads");
		cmp({o_wake, o_ext_irq_source}, 32'h0, "reset requests");
		for (int a = 0; a < 5; a++) begin
			apb(1'b0, 12'(a * 4), 32'h0);
			cmp(rd, 32'h0, "reset value");
		end
		apb(1'b1, 12'h014, 32'hFFFF_FFFF);
		apb(1'b0, 12'h014, 32'h0);
		cmp(err, 1'b1, "unmapped error");
		cmp(rd, 32'h0, "unmapped read");
		$display("test reset done");
	endtask : t_reset
	task automatic t_io;
		put(8'hA5);
		apb(1'b1, OFS_PORT_DATA, 32'h5A);
		apb(1'b0, OFS_PORT_DATA, 32'h0);
		cmp(rd, 32'hA5, "input read");
		cmp(o_pin_oe, 8'h00, "input drive");
		apb(1'b1, OFS_PORT_OPT, 32'hFF);
		apb(1'b1, OFS_PORT_DIR, 32'hFF);
		ext_en <= 8'h00;
		apb(1'b0, OFS_PORT_DATA, 32'h0);
		cmp(rd, 32'h5A, "output read");
		cmp(i_pin_in, 8'h5A, "push-pull pad");
		apb(1'b1, OFS_PORT_OPT, 32'h00);
		put(8'h00);
		cmp(o_pin_oe, 8'hA5, "open-drain drive");
		apb(1'b1, OFS_PORT_DIR, 32'h00);
		apb(1'b1, OFS_PORT_OPT, 32'hFF);
		put(8'h00);
		cmp(o_pullup_en, 8'hFF, "pull-up");
		apb(1'b0, OFS_PORT_DATA, 32'h0);
		cmp(rd, 32'hFF, "pulled read");
		apb(1'b1, OFS_PORT_OPT, 32'h00);
		ext_en <= 8'hFF;
		$display("test io done");
	endtask : t_io
	task automatic t_alt;
		i_alt_en <= 8'h0F;
		i_alt_out_en <= 8'h0F;
		i_alt_out <= 8'h05;
		i_alt_od <= 8'h0C;
		put(8'h00);
		cmp(o_pin_oe, 8'h0B, "alt drive");
		cmp(o_pin_out & 8'h0F, 8'h05, "alt value");
		apb(1'b0, OFS_PORT_DATA, 32'h0);
		cmp(rd, 32'h05, "alt read");
		i_alt_out_en <= 8'h00;
		apb(1'b1, OFS_PORT_DATA, 32'h0A);
		apb(1'b1, OFS_PORT_DIR, 32'h0F);
		// upper pins stay inputs, so the peripheral sees their pad level
		put(8'h50);
		cmp(o_alt_in & 8'h0F, 8'h0A, "alt input");
		cmp(o_alt_in & 8'hF0, 8'h50, "alt pad input");
		i_alt_en <= 8'h00;
		apb(1'b1, OFS_PORT_DIR, 32'h00);
		$display("test alt done");
	endtask : t_alt
	task automatic t_irq;
		apb(1'b1, OFS_PORT_OPT, 32'h13);
		apb(1'b1, OFS_SENS_CTRL, 32'h5);
		put(8'hEC);
		fetch(2'b11);
		wait_irq(2'b00);
		put(8'hED);
		wait_irq(2'b01);
		put(8'hFD);
		wait_irq(2'b11);
		cmp(o_wake, 1'b1, "wake");
		fetch(2'b01);
		wait_irq(2'b10);
		apb(1'b1, OFS_SENS_CTRL, 32'h9);
		wait_irq(2'b00);
		cmp(o_wake, 1'b0, "no wake");
		put(8'hFF);
		wait_irq(2'b01);
		for (int m = 0; m < 4; m++) begin
			put({7'h7F, ~m[0]});
			apb(1'b1, OFS_SENS_CTRL, {28'h0, 2'b10, 2'(m)});
			fetch(2'b01);
			wait_irq(2'b00);
			put({7'h7F, m[0]});
			wait_irq(2'b01);
		end
		$display("test irq done");
	endtask : t_irq
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	// watchdog sized well above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		$display("CHECK FAILED %0t watchdog", $time);
		print_verdict();
	end
	initial begin
		{i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_vec_fetch} = '0;
		{i_alt_en, i_alt_out_en, i_alt_out, i_alt_od, ext} = '0;
		ext_en = 8'hFF;
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_io();
		t_alt();
		t_irq();
		print_verdict();
	end
endmodule : testbench
